// >>> hdl/clock_watch.sv
/*
 Watches one clock pin by sampling it on clk_sys: stop detection and lock.
 Assumes the pin toggles well below half the clk_sys rate.
*/
`timescale 1ns/1ps
module clock_watch
	import sink_flow_pkg::*;
#(
	parameter int unsigned STOP_N = STOP_CYCLES,
	parameter int unsigned LOCK_N = LOCK_CYCLES
)
(
	// System
	input wire logic clk_sys,
	input wire logic srst,
	// Watched pin (synchronised here) and manager reset (already synchronised)
	input wire logic pin,
	input wire logic hold,
	// Results
	output logic level,
	output logic stopped,
	output logic locked
);
	logic s1_q, s2_q, s3_q;
	logic [15:0] idle_q;
	logic [15:0] run_q;
	logic edge_seen;

	always_ff @(posedge clk_sys)
	begin
		s1_q <= pin;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	assign edge_seen = s2_q ^ s3_q;
	assign level = s3_q;

	// Idle cycles since the last edge
	always_ff @(posedge clk_sys)
	begin
		if (srst || edge_seen)
			idle_q <= 16'h0000;
		else if (idle_q < 16'(STOP_N))
			idle_q <= idle_q + 16'h0001;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			stopped <= 1'b0;
		else
			stopped <= (idle_q >= 16'(STOP_N));
	end

	// Lock needs an unbroken run; reset or a stop restarts it
	always_ff @(posedge clk_sys)
	begin
		if (srst || hold || stopped)
			run_q <= 16'h0000;
		else if (run_q < 16'(LOCK_N))
			run_q <= run_q + 16'h0001;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst || hold)
			locked <= 1'b0;
		else
			locked <= (run_q >= 16'(LOCK_N)) && !stopped;
	end
endmodule

// >>> hdl/sink_flow_pkg.sv
/*
 Constants, register map and carrier types for the sink flow-status block.
 Assumes one 25 MHz system clock that also stands for the data rate.
*/
// Summary of operation
// - Release threshold is clamped between the assert threshold and 508.
// - Nearly-full releases once free space reaches the release threshold; real status resumes.
// - Status clock runs at quarter rate for divide select 0, eighth rate for 1.
// - Status output changes on status clock rising edge for select 0, falling for 1.
// - Policy 00: out of frame while nearly full, framing code 11 sent.
// - Policy 01: stay in frame, send satisfied code 10 until release.
// - Policy 10 or 11: stay in frame, pass user status unchanged.
// - Two clocking configurations: built-in clock generation or user supplied clocks.
// - Built-in configuration exports full-rate receive clock and its inverse.
// - Input resets the receive clock manager; output reports its lock.
// - Lost-clock output rises when the receive data clock has stopped.
// - Clocks-ready output only when every sink clock is ready.
// - Nearly-full asserts when free space falls to the assert threshold.
package sink_flow_pkg;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned STOP_TIME_NS = 200;
	localparam int unsigned STOP_CYCLES = (STOP_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : STOP_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned LOCK_TIME_NS = 1000;
	localparam int unsigned LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HALF_QUARTER = 2;
	localparam int unsigned HALF_EIGHTH = 4;

	localparam int unsigned THR_W = 9;
	localparam logic [8:0] AF_MIN = 9'h001;
	localparam logic [8:0] AF_MAX = 9'h1FC;
	localparam logic [8:0] ASSERT_RST = 9'h010;
	localparam logic [8:0] RELEASE_RST = 9'h020;

	localparam logic [1:0] CODE_FRAMING = 2'h3;
	localparam logic [1:0] CODE_SATISFIED = 2'h2;
	localparam logic [1:0] POL_OOF = 2'h0;
	localparam logic [1:0] POL_SATISFY = 2'h1;

	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_THRESH = 12'h004;
	localparam logic [11:0] OFF_STATE = 12'h008;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h00C;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h010;

	localparam int unsigned CTRL_DIV_BIT = 0;
	localparam int unsigned CTRL_EDGE_BIT = 1;
	localparam int unsigned CTRL_POL_LSB = 2;
	localparam int unsigned CTRL_USERCLK_BIT = 4;
	localparam int unsigned THR_ASSERT_LSB = 0;
	localparam int unsigned THR_RELEASE_LSB = 16;

	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_AF_ON = 0;
	localparam int unsigned IRQ_AF_OFF = 1;
	localparam int unsigned IRQ_STOP = 2;
	localparam int unsigned IRQ_UNLOCK = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_type;
endpackage

// >>> hdl/sink_flow_status.sv
/*
 Sink flow-status, status channel clocking and clock monitoring, with an
 AXI4-Lite register slave and a level interrupt.
 Assumes free-space count and user status come from logic on clk_sys.
*/
`timescale 1ns/1ps
module sink_flow_status
	import sink_flow_pkg::*;
#(
	parameter int unsigned STOP_N = STOP_CYCLES,
	parameter int unsigned LOCK_N = LOCK_CYCLES
)
(
	// System
	input wire logic clk_sys,
	input wire logic srst,
	// Register bus
	input wire axil_req_type axil_req,
	output axil_rsp_type axil_rsp,
	// Sink fifo side
	input wire logic [8:0] free_locations,
	input wire logic [1:0] user_status,
	output logic rx_fifo_nearly_full_n,
	output logic rx_out_of_frame,
	// Status channel
	output logic status_channel_clock,
	output logic [1:0] status_channel_out,
	// Clocking pins
	input wire logic rx_data_clock,
	input wire logic rx_clock_supplied,
	input wire logic rx_clock_inverted_supplied,
	input wire logic rx_clock_manager_reset,
	output logic rx_clock_exported,
	output logic rx_clock_inverted_exported,
	output logic rx_clock_manager_locked,
	output logic rx_clock_stopped,
	output logic rx_clocks_all_ready,
	// Interrupt
	output logic irq
);
	localparam int unsigned NUM_WATCH = 3;

	logic div_q, edge_q, userclk_q;
	logic [1:0] policy_q;
	logic [8:0] asrt_q, rel_q;
	logic [8:0] asrt_eff, rel_eff;
	logic af_q;
	logic [3:0] div_cnt_q;
	logic sclk_q, sclk_toggle, upd;
	logic [1:0] stat_q;
	logic [1:0] code_d, bresp_q, rresp_q;
	logic mrst_s1_q, mrst_q;
	logic [NUM_WATCH-1:0] pins, w_level, w_stop, w_lock;
	logic locked_d, ready_d;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_event;
	logic af_prev_q, stop_prev_q, lock_prev_q;
	logic aw_got_q, w_got_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire, bvalid_q, rvalid_q;
	logic [31:0] rdata_d, rdata_q;
	logic [31:0] ctrl_v, thr_v, mask_v;
	logic rd_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// Threshold clamps
	always_comb
	begin
		asrt_eff = asrt_q;
		if (asrt_q < AF_MIN)
			asrt_eff = AF_MIN;
		else if (asrt_q > AF_MAX)
			asrt_eff = AF_MAX;
		rel_eff = rel_q;
		if (rel_q < asrt_eff)
			rel_eff = asrt_eff;
		else if (rel_q > AF_MAX)
			rel_eff = AF_MAX;
	end

	// Nearly-full with hysteresis
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			af_q <= 1'b0;
		else if (!af_q && free_locations <= asrt_eff)
			af_q <= 1'b1;
		else if (af_q && free_locations >= rel_eff)
			af_q <= 1'b0;
	end

	assign rx_fifo_nearly_full_n = !af_q;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			rx_out_of_frame <= 1'b0;
		else
			rx_out_of_frame <= af_q && (policy_q == POL_OOF);
	end

	// Status clock divider; a static select is expected, a live change only bends one period
	always_ff @(posedge clk_sys)
	begin
		if (srst || sclk_toggle)
			div_cnt_q <= 4'h0;
		else
			div_cnt_q <= div_cnt_q + 4'h1;
	end

	assign sclk_toggle = div_q ? (div_cnt_q == 4'(HALF_EIGHTH - 1)) : (div_cnt_q == 4'(HALF_QUARTER - 1));

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			sclk_q <= 1'b0;
		else if (sclk_toggle)
			sclk_q <= !sclk_q;
	end

	assign status_channel_clock = sclk_q;
	assign upd = sclk_toggle && (sclk_q == edge_q);

	always_comb
	begin
		code_d = user_status;
		if (af_q && policy_q == POL_OOF)
			code_d = CODE_FRAMING;
		else if (af_q && policy_q == POL_SATISFY)
			code_d = CODE_SATISFIED;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			stat_q <= CODE_FRAMING;
		else if (upd)
			stat_q <= code_d;
	end

	assign status_channel_out = stat_q;

	// Clock monitoring; manager reset is a pin
	always_ff @(posedge clk_sys)
	begin
		mrst_s1_q <= rx_clock_manager_reset;
		mrst_q <= mrst_s1_q;
	end

	assign pins = {rx_clock_inverted_supplied, rx_clock_supplied, rx_data_clock};

	generate
		for (genvar g = 0; g < NUM_WATCH; g++)
		begin : g_watch
			clock_watch #(.STOP_N(STOP_N), .LOCK_N(LOCK_N)) u_watch (
				.clk_sys(clk_sys),
				.srst(srst),
				.pin(pins[g]),
				.hold(mrst_q),
				.level(w_level[g]),
				.stopped(w_stop[g]),
				.locked(w_lock[g])
			);
		end
	endgenerate

	// User mode also needs both supplied clocks running
	assign locked_d = w_lock[0];
	assign ready_d = locked_d && !mrst_q && (!userclk_q || (w_lock[1] && w_lock[2]));

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rx_clock_exported <= 1'b0;
			rx_clock_inverted_exported <= 1'b0;
			rx_clock_manager_locked <= 1'b0;
			rx_clock_stopped <= 1'b0;
			rx_clocks_all_ready <= 1'b0;
		end
		else
		begin
			rx_clock_exported <= !userclk_q && w_level[0];
			rx_clock_inverted_exported <= !userclk_q && !w_level[0];
			rx_clock_manager_locked <= locked_d;
			rx_clock_stopped <= w_stop[0];
			rx_clocks_all_ready <= ready_d;
		end
	end

	// Interrupt events
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			af_prev_q <= 1'b0;
			stop_prev_q <= 1'b0;
			lock_prev_q <= 1'b0;
		end
		else
		begin
			af_prev_q <= af_q;
			stop_prev_q <= w_stop[0];
			lock_prev_q <= locked_d;
		end
	end

	always_comb
	begin
		irq_event = '0;
		irq_event[IRQ_AF_ON] = af_q && !af_prev_q;
		irq_event[IRQ_AF_OFF] = !af_q && af_prev_q;
		irq_event[IRQ_STOP] = w_stop[0] && !stop_prev_q;
		irq_event[IRQ_UNLOCK] = !locked_d && lock_prev_q;
	end

	// AXI4-Lite write: address and data taken in either order
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (axil_req.awvalid && axil_rsp.awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= axil_req.awaddr;
			end
			else if (wr_fire)
				aw_got_q <= 1'b0;
			if (axil_req.wvalid && axil_rsp.wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= axil_req.wdata;
				wstrb_q <= axil_req.wstrb;
			end
			else if (wr_fire)
				w_got_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= (awaddr_q == OFF_CTRL || awaddr_q == OFF_THRESH || awaddr_q == OFF_IRQ_STAT
				|| awaddr_q == OFF_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (axil_req.bready)
			bvalid_q <= 1'b0;
	end

	// Control and threshold registers; byte strobes merged outside the clocked process
	assign ctrl_v = merge({27'h0, userclk_q, policy_q, edge_q, div_q}, wdata_q, wstrb_q);
	assign thr_v = merge({7'h0, rel_q, 7'h0, asrt_q}, wdata_q, wstrb_q);
	assign mask_v = merge({28'h0, irq_mask_q}, wdata_q, wstrb_q);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			div_q <= 1'b0;
			edge_q <= 1'b0;
			policy_q <= POL_OOF;
			userclk_q <= 1'b0;
			asrt_q <= ASSERT_RST;
			rel_q <= RELEASE_RST;
			irq_mask_q <= '0;
		end
		else if (wr_fire)
		begin
			if (awaddr_q == OFF_CTRL)
			begin
				div_q <= ctrl_v[CTRL_DIV_BIT];
				edge_q <= ctrl_v[CTRL_EDGE_BIT];
				policy_q <= ctrl_v[CTRL_POL_LSB +: 2];
				userclk_q <= ctrl_v[CTRL_USERCLK_BIT];
			end
			if (awaddr_q == OFF_THRESH)
			begin
				asrt_q <= thr_v[THR_ASSERT_LSB +: THR_W];
				rel_q <= thr_v[THR_RELEASE_LSB +: THR_W];
			end
			if (awaddr_q == OFF_IRQ_MASK)
				irq_mask_q <= mask_v[IRQ_W-1:0];
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			irq_stat_q <= '0;
		else if (wr_fire && awaddr_q == OFF_IRQ_STAT && wstrb_q[0])
			irq_stat_q <= (irq_stat_q & ~wdata_q[IRQ_W-1:0]) | irq_event;
		else
			irq_stat_q <= irq_stat_q | irq_event;
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// AXI4-Lite read, one cycle to rvalid
	// Whole response struct from one driver
	assign axil_rsp = '{awready: !aw_got_q && !bvalid_q, wready: !w_got_q && !bvalid_q, bvalid: bvalid_q,
		bresp: bresp_q, arready: !rvalid_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		rd_hit = 1'b1;
		case (axil_req.araddr)
			OFF_CTRL: rdata_d = {27'h0, userclk_q, policy_q, edge_q, div_q};
			OFF_THRESH: rdata_d = {7'h0, rel_q, 7'h0, asrt_q};
			OFF_STATE: rdata_d = {7'h0, free_locations, 9'h000, stat_q, rx_clocks_all_ready,
				rx_clock_stopped, rx_clock_manager_locked, rx_out_of_frame, af_q};
			OFF_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
			OFF_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end
		else if (axil_req.arvalid && axil_rsp.arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rdata_d;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (axil_req.rready)
			rvalid_q <= 1'b0;
	end

	a_release_clamp:
	assert property (@(posedge clk_sys) disable iff (srst) rel_eff >= asrt_eff && rel_eff <= AF_MAX)
		else $error("release threshold out of range");

	a_af_release:
	assert property (@(posedge clk_sys) disable iff (srst) af_q && free_locations >= rel_eff |=> !af_q)
		else $error("nearly-full not released");

	a_af_assert:
	assert property (@(posedge clk_sys) disable iff (srst) !af_q && free_locations <= asrt_eff |=> af_q)
		else $error("nearly-full not asserted");

	a_af_hold:
	assert property (@(posedge clk_sys) disable iff (srst) af_q && free_locations < rel_eff |=> af_q)
		else $error("nearly-full dropped early");

	a_div_period:
	assert property (@(posedge clk_sys) disable iff (srst)
		$rose(sclk_q) && !div_q && $stable(div_q) ##1 !div_q |-> sclk_q ##1 !sclk_q)
		else $error("status clock not quarter rate");

	a_edge_phase:
	assert property (@(posedge clk_sys) disable iff (srst)
		$changed(stat_q) |-> ($past(edge_q) ? $fell(sclk_q) : $rose(sclk_q)))
		else $error("status changed on wrong edge");

	a_oof_code:
	assert property (@(posedge clk_sys) disable iff (srst)
		upd && af_q && policy_q == POL_OOF |=> stat_q == CODE_FRAMING ##0 rx_out_of_frame)
		else $error("framing code missing");

	a_satisfied:
	assert property (@(posedge clk_sys) disable iff (srst)
		upd && af_q && policy_q == POL_SATISFY |=> stat_q == CODE_SATISFIED && !rx_out_of_frame)
		else $error("satisfied code missing");

	a_pass_user:
	assert property (@(posedge clk_sys) disable iff (srst)
		upd && policy_q[1] |=> stat_q == $past(user_status) && !rx_out_of_frame)
		else $error("user status not passed");

	a_ready_gate:
	assert property (@(posedge clk_sys) disable iff (srst)
		!locked_d || mrst_q |=> !rx_clocks_all_ready)
		else $error("clocks ready while unlocked");

	a_lock_reset:
	assert property (@(posedge clk_sys) disable iff (srst) mrst_q |=> ##1 !rx_clock_manager_locked)
		else $error("lock kept under manager reset");
endmodule

// >>> verif/sink_flow_status_tb.sv
/*
 Self-checking bench for sink_flow_status with a reference model of the
 nearly-full hysteresis, policies and status clock; clock monitor checked against fixed values.
 Assumes a shortened lock count and a longer stop count set through the parameters.
*/
`timescale 1ns/1ps
module sink_flow_status_tb
	import sink_flow_pkg::*;
;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	axil_req_type axil_req = '0;
	axil_rsp_type axil_rsp;
	logic [8:0] free_locations = 9'h1FF;
	logic [1:0] user_status = 2'h0;
	logic rx_data_clock = 1'b0;
	logic rx_clock_supplied = 1'b0;
	logic rx_clock_inverted_supplied = 1'b1;
	logic rx_clock_manager_reset = 1'b0;
	logic nf_n, oof, sclk, exp_clk, exp_inv, locked, stopped, ready, irq, halt;
	logic [1:0] sout, seen, resp, prev_out;
	logic prev_clk;
	logic [31:0] rd;
	logic [31:0] lfsr_q = 32'h00002176;
	int period;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	logic run_q = 1'b0;
	logic chk_on = 1'b0;
	logic edge_m = 1'b0;
	logic af_m = 1'b0;
	logic oof_m = 1'b0;
	logic [1:0] pol_m = 2'h0;
	int a_m = 16;
	int r_m = 32;

	sink_flow_status #(.STOP_N(6), .LOCK_N(8)) uut (.clk_sys(clk_sys), .srst(srst), .axil_req(axil_req),
		.axil_rsp(axil_rsp), .free_locations(free_locations), .user_status(user_status),
		.rx_fifo_nearly_full_n(nf_n), .rx_out_of_frame(oof), .status_channel_clock(sclk),
		.status_channel_out(sout), .rx_data_clock(rx_data_clock), .rx_clock_supplied(rx_clock_supplied),
		.rx_clock_inverted_supplied(rx_clock_inverted_supplied), .rx_clock_manager_reset(rx_clock_manager_reset),
		.rx_clock_exported(exp_clk), .rx_clock_inverted_exported(exp_inv), .rx_clock_manager_locked(locked),
		.rx_clock_stopped(stopped), .rx_clocks_all_ready(ready), .irq(irq));

	status_reader far_end (.clk_sys(clk_sys), .status_channel_clock(sclk), .status_channel_out(sout),
		.edge_sel(edge_m), .nearly_full_n(nf_n), .seen_code(seen), .period(period), .halt(halt));

	always #20 clk_sys = ~clk_sys;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int clampi(input int v, input int lo, input int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction

	function automatic logic af_next(input logic af, input int free);
		int ae;
		int re;
		ae = clampi(a_m, 1, 508);
		re = clampi(r_m, ae, 508);
		return af ? !(free >= re) : (free <= ae);
	endfunction

	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		comparisons++;
		if (seen_v !== exp_v)
		begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask

	task report_and_stop;
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Pin clocks well below a quarter of clk_sys; supplied pair always runs
	always @(posedge clk_sys)
	begin
		lfsr_q <= lfsr_next(lfsr_q);
		cyc <= cyc + 1;
		if (run_q && cyc % 3 == 0) rx_data_clock <= ~rx_data_clock;
		if (cyc % 3 == 0) rx_clock_supplied <= ~rx_clock_supplied;
		if (cyc % 3 == 0) rx_clock_inverted_supplied <= rx_clock_supplied;
		af_m <= srst ? 1'b0 : af_next(af_m, free_locations);
		oof_m <= !srst && af_m && pol_m == POL_OOF;
	end

	always @(negedge clk_sys)
	begin
		if (chk_on)
		begin
			check(nf_n, !af_m);
			check(oof, oof_m);
			if (sout !== prev_out) check({sclk != prev_clk, sclk}, {1'b1, !edge_m});
		end
		prev_out <= sout;
		prev_clk <= sclk;
	end

	task automatic axi_wr(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		@(posedge clk_sys);
		axil_req.awaddr <= addr;
		axil_req.wdata <= data;
		axil_req.wstrb <= 4'hF;
		axil_req.awvalid <= 1'b1;
		axil_req.wvalid <= 1'b1;
		axil_req.bready <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok)
		begin
			@(negedge clk_sys);
			aw_ok = axil_req.awvalid && axil_rsp.awready;
			w_ok = axil_req.wvalid && axil_rsp.wready;
			b_ok = axil_rsp.bvalid === 1'b1;
			r = axil_rsp.bresp;
			@(posedge clk_sys);
			if (aw_ok) axil_req.awvalid <= 1'b0;
			if (w_ok) axil_req.wvalid <= 1'b0;
			if (b_ok) axil_req.bready <= 1'b0;
		end
	endtask

	task automatic axi_rd(input logic [11:0] addr, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok, r_ok;
		@(posedge clk_sys);
		axil_req.araddr <= addr;
		axil_req.arvalid <= 1'b1;
		axil_req.rready <= 1'b1;
		r_ok = 1'b0;
		while (!r_ok)
		begin
			@(negedge clk_sys);
			ar_ok = axil_req.arvalid && axil_rsp.arready;
			r_ok = axil_rsp.rvalid === 1'b1;
			d = axil_rsp.rdata;
			r = axil_rsp.rresp;
			@(posedge clk_sys);
			if (ar_ok) axil_req.arvalid <= 1'b0;
			if (r_ok) axil_req.rready <= 1'b0;
		end
	endtask

	// Free space parked high so model and design both leave nearly-full clear
	task automatic cfg(input logic [31:0] ctrl, input logic [8:0] a, input logic [8:0] r);
		chk_on = 1'b0;
		free_locations <= 9'h1FF;
		axi_wr(OFF_CTRL, ctrl, resp);
		axi_wr(OFF_THRESH, {7'h00, r, 7'h00, a}, resp);
		edge_m = ctrl[CTRL_EDGE_BIT];
		pol_m = ctrl[CTRL_POL_LSB +: 2];
		a_m = a;
		r_m = r;
		repeat (12) @(posedge clk_sys);
		chk_on = 1'b1;
	endtask

	initial
	begin
		#(40 * 20000);
		err_total++;
		report_and_stop;
	end

	initial
	begin
		int i;
		logic [8:0] ta [4] = '{9'h010, 9'h030, 9'h000, 9'h1FF};
		logic [8:0] tr [4] = '{9'h020, 9'h010, 9'h1FF, 9'h100};
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		check(nf_n, 1'b1);
		axi_rd(OFF_THRESH, rd, resp);
		check(rd, {7'h00, RELEASE_RST, 7'h00, ASSERT_RST});
		axi_rd(12'h0FC, rd, resp);
		check(resp, RESP_SLVERR);
		axi_wr(OFF_STATE, 32'h00000000, resp);
		check(resp, RESP_SLVERR);
		$display("test reset and map done");
		for (i = 0; i < 2; i++)
		begin
			cfg(i, 9'h010, 9'h020);
			check(resp, RESP_OKAY);
			repeat (40) @(posedge clk_sys);
			check(period, 4 << i);
		end
		$display("test status clock rate done");
		for (i = 0; i < 4; i++)
		begin
			cfg({28'h0, i[1:0], i[0], i[1]}, 9'h010, 9'h020);
			user_status <= lfsr_q[1:0];
			free_locations <= 9'h005;
			repeat (40) @(posedge clk_sys);
			check(seen, i == 0 ? CODE_FRAMING : (i == 1 ? CODE_SATISFIED : user_status));
			check(halt, 1'b1);
			free_locations <= 9'h1FF;
			repeat (40) @(posedge clk_sys);
			check(seen, user_status);
			check(halt, 1'b0);
		end
		$display("test policies done");
		for (i = 0; i < 4; i++)
		begin
			cfg({30'h0, i[0], i[1]}, ta[i], tr[i]);
			repeat (400)
			begin
				@(posedge clk_sys);
				free_locations <= lfsr_q[8:0];
				user_status <= lfsr_q[10:9];
			end
		end
		$display("test random thresholds done");
		cfg(32'h00000000, 9'h010, 9'h020);
		run_q <= 1'b1;
		repeat (100) @(posedge clk_sys);
		check({locked, stopped, ready}, 3'b101);
		check(exp_clk ^ exp_inv, 1'b1);
		axi_wr(OFF_IRQ_MASK, 32'h00000004, resp);
		axi_wr(OFF_IRQ_STAT, 32'h0000000F, resp);
		check(irq, 1'b0);
		run_q <= 1'b0;
		repeat (30) @(posedge clk_sys);
		check({stopped, ready, irq}, 3'b101);
		axi_rd(OFF_IRQ_STAT, rd, resp);
		check(rd[IRQ_W-1:0], (4'h1 << IRQ_STOP) | (4'h1 << IRQ_UNLOCK));
		axi_wr(OFF_IRQ_STAT, 32'h00000004, resp);
		check(irq, 1'b0);
		rx_clock_manager_reset <= 1'b1;
		run_q <= 1'b1;
		repeat (30) @(posedge clk_sys);
		check({locked, ready}, 2'b00);
		rx_clock_manager_reset <= 1'b0;
		repeat (60) @(posedge clk_sys);
		check({locked, ready}, 2'b11);
		cfg(32'h00000001 << CTRL_USERCLK_BIT, 9'h010, 9'h020);
		repeat (60) @(posedge clk_sys);
		check({ready, exp_clk, exp_inv}, 3'b100);
		$display("test clocking done");
		report_and_stop;
	end
endmodule

// >>> verif/status_reader.sv
/*
 Behavioural far-side reader of the status channel: samples the code on the
 edge opposite to the change edge and measures the status clock period.
 Assumes clk_sys is the same system clock that drives the design.
*/
`timescale 1ns/1ps
module status_reader
(
	// System
	input wire logic clk_sys,
	// Status channel
	input wire logic status_channel_clock,
	input wire logic [1:0] status_channel_out,
	input wire logic edge_sel,
	input wire logic nearly_full_n,
	// Observations
	output logic [1:0] seen_code,
	output int period,
	output logic halt
);
	int count = 0;
	logic sclk_prev = 1'b0;

	// Sample away from the change edge, where the code is settled
	always @(status_channel_clock)
		if (status_channel_clock == edge_sel) seen_code <= status_channel_out;

	// Negedge sampling avoids racing the design's registered clock
	always @(negedge clk_sys)
	begin
		sclk_prev <= status_channel_clock;
		count <= count + 1;
		if (status_channel_clock && !sclk_prev)
		begin
			period <= count + 1;
			count <= 0;
		end
		halt <= !nearly_full_n;
	end
endmodule
